// file: hw/_unused_guard.sv
`default_nettype none
`default_nettype wire

// file: hw/sac_port.sv
// Serial control port of an 8-bit successive-approximation converter, with result FIFO.
// Assumes an external comparator and trial DAC driven from sar_code_o, and a tri-state pad.
//
// What this block does and what it expects of the host
// [R1] After chip-select falls, control inputs are ignored until two rising and one falling internal clock edges.
// [R2] The host waits the chip-select setup time before clocking in address bits.
// [R3] The data output floats while chip-select is high and after the eighth falling I/O clock edge.
// [R4] End-of-conversion goes high once a conversion finishes and its result is available.
// [R5] The channel address selects one of eleven analog inputs or the self-test voltage.
// [R6] Sampling starts only when a serial transfer from the host requests it.
// [R7] Each result is an 8-bit code built by successive approximation.
// [R8] The link is I/O clock, chip-select and address inputs plus one tri-state data output.
// [R9] Each address bit is captured on a rising I/O clock edge.
// [R10] The host keeps chip-select low until after the eighth rising I/O clock edge.
// [R11] Each transfer shifts a 4-bit address in and the previous result out, both MSB first.
`default_nettype none

module sac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;

  always_comb begin
    out_valid_o = (wr_ptr != rd_ptr);
    in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_data_o = mem[rd_ptr[AW-1:0]];
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : sac_fifo

module sac_port (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic io_clk_i,
  input wire logic cs_n_i,
  input wire logic addr_in_i,
  output logic data_out_o,
  output logic data_out_oe_n_o,
  output logic eoc_o,
  output logic [3:0] chan_sel_o,
  output logic sample_o,
  output logic [7:0] sar_code_o,
  input wire logic cmp_i
);
  // Out-of-range addresses fall back to the self-test source
  function automatic logic [3:0] chan_of(input logic [3:0] a);
    chan_of = (a > sac_pkg::SELFTEST_CHAN) ? sac_pkg::SELFTEST_CHAN : a; // see [R5]
  endfunction : chan_of

  // System domain: synchronisers
  logic cs_meta;
  logic cs_sync;
  logic tg_meta;
  logic tg_sync;
  logic tg_seen;
  logic cmp_meta;
  logic cmp_sync;
  logic xfer_tgl;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      tg_meta <= 1'b0;
      tg_sync <= 1'b0;
      tg_seen <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cs_meta <= cs_n_i;
      cs_sync <= cs_meta;
      tg_meta <= xfer_tgl;
      tg_sync <= tg_meta;
      tg_seen <= tg_sync;
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
    end
  end

  logic xfer_evt;
  assign xfer_evt = tg_sync ^ tg_seen;

  // Internal system clock and chip-select noise filter
  logic [sac_pkg::CNT_W-1:0] div_cnt;
  logic [sac_pkg::CNT_W-1:0] next_div_cnt;
  logic int_clk;
  logic next_int_clk;
  logic [1:0] rise_seen;
  logic [1:0] next_rise_seen;
  logic [1:0] fall_seen;
  logic [1:0] next_fall_seen;
  logic armed;
  logic next_armed;

  always_comb begin
    next_div_cnt = div_cnt + 1'b1;
    next_int_clk = int_clk;
    next_rise_seen = rise_seen;
    next_fall_seen = fall_seen;
    if (div_cnt == sac_pkg::INT_LAST) begin
      next_div_cnt = '0;
      next_int_clk = !int_clk;
      if (!int_clk && rise_seen < sac_pkg::CS_RISE_NEED) begin
        next_rise_seen = rise_seen + 1'b1;
      end
      if (int_clk && rise_seen != 2'h0 && fall_seen < sac_pkg::CS_FALL_NEED) begin
        next_fall_seen = fall_seen + 1'b1;
      end
    end
    if (cs_sync) begin
      next_rise_seen = '0;
      next_fall_seen = '0;
    end
    next_armed = (next_rise_seen == sac_pkg::CS_RISE_NEED) && (next_fall_seen == sac_pkg::CS_FALL_NEED); // see [R1]
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= '0;
      int_clk <= 1'b0;
      rise_seen <= '0;
      fall_seen <= '0;
      armed <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      int_clk <= next_int_clk;
      rise_seen <= next_rise_seen;
      fall_seen <= next_fall_seen;
      armed <= next_armed;
    end
  end

  // Link domain. Frame logic is held reset until armed; the host's setup wait
  // guarantees no I/O clock edge lands near that release.
  logic io_rst_n;
  assign io_rst_n = reset_n_i && armed && !cs_n_i; // see [R1] see [R2]

  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic [3:0] addr_sh;
  logic [3:0] next_addr_sh;

  always_comb begin
    next_rise_cnt = rise_cnt;
    next_addr_sh = addr_sh;
    if (rise_cnt < sac_pkg::XFER_BITS) begin
      next_rise_cnt = rise_cnt + 1'b1;
    end
    if (rise_cnt < sac_pkg::ADDR_BITS) begin
      next_addr_sh = {addr_sh[2:0], addr_in_i}; // see [R9] see [R11]
    end
  end

  always_ff @(posedge io_clk_i or negedge io_rst_n) begin
    if (!io_rst_n) begin
      rise_cnt <= '0;
      addr_sh <= '0;
    end else begin
      rise_cnt <= next_rise_cnt;
      addr_sh <= next_addr_sh;
    end
  end

  // Survives chip-select so the request is not lost when the frame ends
  logic [3:0] addr_hold;
  logic [3:0] next_addr_hold;
  logic next_xfer_tgl;

  always_comb begin
    next_addr_hold = addr_hold;
    next_xfer_tgl = xfer_tgl;
    if (rise_cnt == sac_pkg::XFER_BITS - 4'h1) begin
      next_addr_hold = addr_sh; // see [R10]
      next_xfer_tgl = !xfer_tgl; // see [R6]
    end
  end

  always_ff @(posedge io_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_hold <= '0;
      xfer_tgl <= 1'b0;
    end else begin
      addr_hold <= next_addr_hold;
      xfer_tgl <= next_xfer_tgl;
    end
  end

  logic [3:0] fall_cnt;
  logic [3:0] next_fall_cnt;

  always_comb begin
    next_fall_cnt = fall_cnt;
    if (fall_cnt < sac_pkg::XFER_BITS) begin
      next_fall_cnt = fall_cnt + 1'b1;
    end
  end

  always_ff @(negedge io_clk_i or negedge io_rst_n) begin
    if (!io_rst_n) begin
      fall_cnt <= '0;
    end else begin
      fall_cnt <= next_fall_cnt;
    end
  end

  // Result word is stable for the whole frame, so the link may read it directly
  logic [sac_pkg::RES_W-1:0] out_word;
  always_comb begin
    data_out_o = out_word[sac_pkg::MSB_IDX - fall_cnt[2:0]]; // see [R11]
    data_out_oe_n_o = !io_rst_n || (fall_cnt == sac_pkg::XFER_BITS); // see [R3] see [R8]
  end

  // Conversion engine
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  logic [sac_pkg::CNT_W-1:0] cnt;
  logic [sac_pkg::CNT_W-1:0] next_cnt;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [sac_pkg::RES_W-1:0] next_sar_code;
  logic [3:0] next_chan;
  logic next_eoc;
  logic next_sample;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [sac_pkg::RES_W-1:0] fifo_out_data;
  logic held;
  logic next_held;
  logic pop;
  logic [sac_pkg::RES_W-1:0] next_out_word;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_bit_idx = bit_idx;
    next_sar_code = sar_code_o;
    next_chan = chan_sel_o;
    next_eoc = eoc_o;
    next_sample = sample_o;
    case (state)
      sac_pkg::S_IDLE: begin
        next_cnt = '0;
        if (xfer_evt) begin
          next_chan = chan_of(addr_hold); // see [R5]
          next_state = sac_pkg::S_ACQ; // see [R6]
          next_eoc = 1'b0;
          next_sample = 1'b1;
        end
      end
      sac_pkg::S_ACQ: begin
        if (cnt == sac_pkg::ACQ_LAST) begin
          next_cnt = '0;
          next_sample = 1'b0;
          next_bit_idx = sac_pkg::MSB_IDX;
          next_sar_code = sac_pkg::SAR_FIRST;
          next_state = sac_pkg::S_CONV;
        end
      end
      sac_pkg::S_CONV: begin
        if (cnt == sac_pkg::SAR_LAST) begin
          next_cnt = '0;
          next_sar_code[bit_idx] = cmp_sync; // see [R7]
          if (bit_idx == 3'h0) begin
            next_state = sac_pkg::S_PUSH;
          end else begin
            next_bit_idx = bit_idx - 3'h1;
            next_sar_code[bit_idx - 3'h1] = 1'b1; // see [R7]
          end
        end
      end
      sac_pkg::S_PUSH: begin
        next_cnt = '0;
        // Stalls here while the result queue is full
        if (fifo_in_ready) begin
          next_eoc = 1'b1; // see [R4]
          next_state = sac_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = sac_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= sac_pkg::S_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      sar_code_o <= sac_pkg::RES_RESET;
      chan_sel_o <= '0;
      eoc_o <= 1'b1;
      sample_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      sar_code_o <= next_sar_code;
      chan_sel_o <= next_chan;
      eoc_o <= next_eoc;
      sample_o <= next_sample;
    end
  end

  // Output word loader: a word is popped only between frames and only
  // after the previous word has been shifted out. The end-of-frame event
  // reaches here no later than chip-select high does, so it cannot be missed.
  always_comb begin
    pop = fifo_out_valid && !held && cs_sync && !xfer_evt;
    next_out_word = pop ? fifo_out_data : out_word;
    next_held = held;
    if (xfer_evt) begin
      next_held = 1'b0;
    end
    if (pop) begin
      next_held = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_word <= sac_pkg::RES_RESET;
      held <= 1'b0;
    end else begin
      out_word <= next_out_word;
      held <= next_held;
    end
  end

  sac_fifo #(
    .WIDTH(sac_pkg::RES_W),
    .DEPTH(sac_pkg::FIFO_DEPTH)
  ) u_res_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(state == sac_pkg::S_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(sar_code_o),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );
endmodule : sac_port
`default_nettype wire

// file: pkg/sac_pkg.sv
// Constants and types for the serial converter control port.
// Assumes a 100 MHz system clock and a free-standing serial link clock.
`default_nettype none
package sac_pkg;
  localparam int CLK_MHZ = 100;
  // Sample-and-hold acquisition window
  localparam int ACQ_TIME_NS = 16000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  // Settling time of one approximation step
  localparam int SAR_BIT_NS = 2000;
  localparam int SAR_BIT_CYCLES = (SAR_BIT_NS * CLK_MHZ + 999) / 1000;
  // Half period of the internal system clock used to filter chip-select
  localparam int INT_HALF_NS = 250;
  localparam int INT_HALF_CYCLES = (INT_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYCLES - 1);
  localparam logic [CNT_W-1:0] SAR_LAST = CNT_W'(SAR_BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INT_HALF_CYCLES - 1);
  localparam int RES_W = 8;
  localparam int ADDR_W = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] XFER_BITS = 4'h8;
  localparam logic [3:0] ADDR_BITS = 4'h4;
  localparam logic [3:0] SELFTEST_CHAN = 4'hb;
  localparam logic [1:0] CS_RISE_NEED = 2'h2;
  localparam logic [1:0] CS_FALL_NEED = 2'h1;
  localparam logic [RES_W-1:0] SAR_FIRST = 8'h80;
  localparam logic [RES_W-1:0] RES_RESET = 8'h00;
  localparam logic [2:0] MSB_IDX = 3'h7;
  typedef enum logic [1:0] {
    S_IDLE,
    S_ACQ,
    S_CONV,
    S_PUSH
  } sac_state_t;
endpackage : sac_pkg
`default_nettype wire

// file: sim/sac_host.sv
// Host model: chip-select, I/O clock and address out, serial result in.
// Assumes the I/O clock stands still outside frames.
`default_nettype none
module sac_host (
  output logic cs_n_o,
  output logic io_clk_o,
  output logic addr_o,
  input wire logic data_i,
  input wire logic oe_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last;
  // A released line shows no stale bit
  wire line = oe_n_i ? ~last : data_i;
  initial begin
    cs_n_o = 1;
    io_clk_o = 0;
    addr_o = 0;
    last = 0;
  end
  always @(posedge io_clk_o) if (!oe_n_i) last <= data_i;
  task automatic frame(input logic [3:0] a, input int n, output logic [7:0] w, output logic z);
    w = 8'h00;
    cs_n_o = 0;
    #1500;
    for (int k = 0; k < n; k++) begin
      addr_o = (k < 4) ? a[3-k] : ~addr_o;
      #7 io_clk_o = 1;
      w = {w[6:0], line};
      #8 io_clk_o = 0;
    end
    #2 z = oe_n_i;
    cs_n_o = 1;
  endtask : frame
endmodule : sac_host
`default_nettype wire

// file: sim/sac_port_asserts.sv
// Checker for the converter control port, system clock domain.
// Assumes it is bound to sac_port and sees only its ports.
`default_nettype none
module sac_port_asserts (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic data_out_oe_n_o,
  input wire logic eoc_o,
  input wire logic [3:0] chan_sel_o,
  input wire logic sample_o,
  input wire logic [7:0] sar_code_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Arming needs the filter edges, far more than eight clocks
  sequence s_quiet;
    data_out_oe_n_o [*8];
  endsequence
  sequence s_busy;
    !eoc_o [*8];
  endsequence
  chk_cs_filter: assert property ($fell(cs_n_i) |-> s_quiet)
    else $error("data output driven before arming");
  chk_cs_float: assert property (cs_n_i |-> data_out_oe_n_o)
    else $error("data output driven while deselected");
  chk_eoc_acq: assert property (sample_o |-> !eoc_o)
    else $error("end flag high during acquisition");
  chk_eoc_done: assert property ($rose(eoc_o) |-> !sample_o && $stable(sar_code_o))
    else $error("end flag rose before result settled");
  chk_chan_range: assert property (chan_sel_o <= 4'hb)
    else $error("channel select out of range");
  chk_host_start: assert property ($rose(sample_o) |-> cs_n_i && $past(cs_n_i))
    else $error("acquisition started inside a frame");
  chk_sample_hold: assert property ($rose(sample_o) |=> sample_o [*8])
    else $error("acquisition window cut short");
  chk_sar_first: assert property ($fell(sample_o) |-> ##[0:2] sar_code_o == 8'h80)
    else $error("first trial code wrong");
  chk_sar_busy: assert property ($fell(sample_o) |-> s_busy)
    else $error("end flag rose before approximation");
endmodule : sac_port_asserts
`default_nettype wire

// file: sim/tb.sv
// Testbench for the converter control port and its result FIFO.
// Assumes the host model and the checker are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 0, reset_n_i = 0, cmp_i = 0;
  wire cs_n, io_clk, addr, dout, oe_n, eoc, smp;
  wire [3:0] chan;
  wire [7:0] code;
  logic [7:0] tgt = 0, prev = 0, w;
  logic z;
  int n_errors = 0, checked = 0;
  sac_port u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .io_clk_i(io_clk), .cs_n_i(cs_n),
    .addr_in_i(addr), .data_out_o(dout), .data_out_oe_n_o(oe_n), .eoc_o(eoc), .chan_sel_o(chan),
    .sample_o(smp), .sar_code_o(code), .cmp_i(cmp_i));
  sac_host u_host (.cs_n_o(cs_n), .io_clk_o(io_clk), .addr_o(addr), .data_i(dout), .oe_n_i(oe_n));
  initial forever #5 clock_i = ~clock_i;
  // Ideal comparator, so the code must settle on the target
  always @(posedge clock_i) cmp_i <= #1 (tgt >= code);
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wait_eoc(input logic lvl);
    int k;
    k = 0;
    while (eoc !== lvl && k < 4000) begin
      @(posedge clock_i);
      k++;
    end
    check(eoc, lvl);
  endtask : wait_eoc
  task t_reset;
    check({eoc, oe_n, smp}, 8'h06);
    check(chan, 8'h00);
    check(code, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task t_short;
    u_host.frame(4'h2, 4, w, z);
    repeat (40) @(posedge clock_i);
    check({eoc, smp}, 8'h02);
    $display("t_short done");
  endtask : t_short
  task t_conv;
    logic [3:0] a;
    for (int i = 0; i < 15; i++) begin
      a = (i == 12) ? 4'hf : 4'(i);
      prev = tgt;
      tgt = (i > 11) ? {8{i[0]}} : 8'h3b * 8'(i) + 8'h11;
      u_host.frame(a, 8, w, z);
      check(w, prev);
      check(z, 1);
      wait_eoc(0);
      wait_eoc(1);
      check(chan, (a > 4'hb) ? 4'hb : a);
      check(code, tgt);
      repeat (5) @(posedge clock_i);
      #1;
    end
    $display("t_conv done");
  endtask : t_conv
  // Result queue seen through the port: a frame sent while busy is ignored and the word waits
  task t_fifo;
    prev = tgt;
    tgt = 8'h5a;
    u_host.frame(4'h3, 8, w, z);
    check(w, prev);
    wait_eoc(0);
    repeat (100) @(posedge clock_i);
    #1;
    u_host.frame(4'h5, 8, w, z);
    check(w, prev);
    check({eoc, smp}, 8'h01);
    check(chan, 4'h3);
    wait_eoc(1);
    check(code, tgt);
    repeat (5) @(posedge clock_i);
    #1;
    u_host.frame(4'h1, 8, w, z);
    check(w, tgt);
    check(z, 1);
    wait_eoc(0);
    wait_eoc(1);
    $display("t_fifo done");
  endtask : t_fifo
  task results;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge clock_i);
    #1 t_reset;
    reset_n_i = 1;
    repeat (2) @(posedge clock_i);
    #1 t_short;
    t_conv;
    t_fifo;
    results;
  end
  // Seventeen conversions need about 58k clocks; stop well before 90k
  initial begin
    #900000;
    n_errors++;
    results;
  end
endmodule : tb
bind sac_port sac_port_asserts u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i),
  .data_out_oe_n_o(data_out_oe_n_o), .eoc_o(eoc_o), .chan_sel_o(chan_sel_o), .sample_o(sample_o),
  .sar_code_o(sar_code_o));
`default_nettype wire
